// file: include/ucr_regs.vh
`ifndef UCR_REGS_VH
`define UCR_REGS_VH

// Register indices; the byte address is four times the index
`define UCR_IDX_DATA      8'hF1
`define UCR_IDX_FLAGS     8'hF2
`define UCR_IDX_SETUP     8'hF3
`define UCR_IDX_DIVISOR   8'hF4
`define UCR_IDX_IRQ_STAT  8'hF5
`define UCR_IDX_IRQ_MASK  8'hF6

// Reset values
`define UCR_FLAGS_RST     8'h02
`define UCR_SETUP_RST     8'h00
`define UCR_DIVISOR_RST   8'hFF
`define UCR_IRQ_RST       4'h0

// serial_port_flags fields
`define UCR_FL_RXFULL     7
`define UCR_FL_PARITY     6
`define UCR_FL_OVERRUN    5
`define UCR_FL_FRAMING    4
`define UCR_FL_BREAK      3
`define UCR_FL_TXRDY      2
`define UCR_FL_TXDONE     1
`define UCR_FL_NOISE      0

// serial_port_setup fields
`define UCR_SU_TXEN       7
`define UCR_SU_RXEN       6
`define UCR_SU_IRQEN      5
`define UCR_SU_PAREN      4
`define UCR_SU_PARODD     3
`define UCR_SU_BREAK      2
`define UCR_SU_STOP2      1
`define UCR_SU_TIMER      0

// Interrupt status and mask fields
`define UCR_IS_RX         0
`define UCR_IS_TX         1
`define UCR_IS_ERR        2
`define UCR_IS_TIMER      3

`endif

// file: hdl/ucr_top.v
// Functional notes
// - data register read clears flag bits seven to three and bit zero
// - bit seven full on receive, empty on read
// - bit six parity error, cleared by read
// - bit five overrun, cleared by data read
// - bit four framing error until data read
// - bit three break detected, cleared by read
// - bit two transmit ready, cleared on write
// - bit one transmit complete, resets to one
// - bit zero reads noise, write sets filter
// - interrupt needs setup bit five and global mask
// - setup bit two forces transmit line low
// - setup bit zero makes generator a timer
// - timer reload raises interrupt when enabled
// - setup kept over stop recovery, reset clears
// - timer mode divisor read returns live count
`timescale 1ns/1ps
`include "ucr_regs.vh"

module ucr_top
(
    // Clock, reset, enable
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        ce,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // Receive shifter events
    input  wire        rx_char_valid,
    input  wire [7:0]  rx_char,
    input  wire        rx_parity_err,
    input  wire        rx_frame_err,
    input  wire        rx_break_seen,
    input  wire        rx_noise_seen,
    // Transmit shifter handshake
    input  wire        tx_taken,
    input  wire        tx_busy,
    output reg         tx_hold_valid,
    output reg  [7:0]  tx_hold_byte,
    output reg         tx_force_low,
    // Configuration to shifters
    output reg         tx_enable,
    output reg         rx_enable,
    output reg         parity_enable,
    output reg         parity_odd,
    output reg         two_stop_bits,
    output reg         noise_filter_on,
    output reg         bit_rate_tick,
    // System
    input  wire        stop_recover,
    input  wire        global_irq_mask,
    output reg         irq
);

////////////////////////////////////////////////////////////////////////////
// Bus decode

reg  [7:0]  rdata_nxt;
reg         wr_pend_r;
reg  [7:0]  wr_idx_r;
reg  [7:0]  serial_port_flags_r;
reg  [7:0]  serial_port_setup_r;
reg  [7:0]  bit_rate_divisor_value_r;
reg  [7:0]  bit_rate_divider_r;
reg  [7:0]  receive_byte_holding_r;
reg  [3:0]  irq_stat_r;
reg  [3:0]  irq_mask_r;
reg  [3:0]  irq_stat_nxt;
reg  [7:0]  flags_nxt;

wire        addr_ok  = hsel & htrans[1] & hready;
wire [7:0]  a_idx    = haddr[9:2];
wire        a_mapped = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0);
wire        rd_acc   = ce & addr_ok & ~hwrite & a_mapped;
wire        wr_now   = ce & wr_pend_r;
wire [7:0]  wd       = hwdata[7:0];

wire        rd_data  = rd_acc & (a_idx == `UCR_IDX_DATA);
wire        wr_data  = wr_now & (wr_idx_r == `UCR_IDX_DATA);
wire        wr_flags = wr_now & (wr_idx_r == `UCR_IDX_FLAGS);
wire        wr_setup = wr_now & (wr_idx_r == `UCR_IDX_SETUP);
wire        wr_div   = wr_now & (wr_idx_r == `UCR_IDX_DIVISOR);
wire        wr_istat = wr_now & (wr_idx_r == `UCR_IDX_IRQ_STAT);
wire        wr_imask = wr_now & (wr_idx_r == `UCR_IDX_IRQ_MASK);

wire        timer_mode = serial_port_setup_r[`UCR_SU_TIMER];
wire        brg_run    = timer_mode | serial_port_setup_r[`UCR_SU_TXEN]
                         | serial_port_setup_r[`UCR_SU_RXEN];
wire        brg_reload = brg_run & (bit_rate_divider_r == 8'h00);

always @*
begin
    case (a_idx)
        `UCR_IDX_DATA:     rdata_nxt = receive_byte_holding_r;
        `UCR_IDX_FLAGS:    rdata_nxt = serial_port_flags_r;
        `UCR_IDX_SETUP:    rdata_nxt = serial_port_setup_r;
        `UCR_IDX_DIVISOR:  rdata_nxt = timer_mode ? bit_rate_divider_r
                                      : bit_rate_divisor_value_r;
        `UCR_IDX_IRQ_STAT: rdata_nxt = {4'h0, irq_stat_r};
        `UCR_IDX_IRQ_MASK: rdata_nxt = {4'h0, irq_mask_r};
        default:           rdata_nxt = 8'h00;
    endcase
    if (!a_mapped)
    begin
        rdata_nxt = 8'h00;
    end
end

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        hrdata    <= 32'h00000000;
        hreadyout <= 1'b0;
        hresp     <= 1'b0;
        wr_pend_r <= 1'b0;
        wr_idx_r  <= 8'h00;
    end
    else if (ce)
    begin
        hreadyout <= 1'b1;
        hresp     <= 1'b0;
        wr_pend_r <= addr_ok & hwrite & a_mapped;
        if (addr_ok)
        begin
            wr_idx_r <= a_idx;
        end
        if (rd_acc)
        begin
            hrdata <= {24'h000000, rdata_nxt};
        end
        else if (addr_ok)
        begin
            hrdata <= 32'h00000000;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Status flags

always @*
begin
    flags_nxt = serial_port_flags_r;
    // A data read empties the holding register and clears the errors
    if (rd_data)
    begin
        flags_nxt[`UCR_FL_RXFULL]  = 1'b0;
        flags_nxt[`UCR_FL_PARITY]  = 1'b0;
        flags_nxt[`UCR_FL_OVERRUN] = 1'b0;
        flags_nxt[`UCR_FL_FRAMING] = 1'b0;
        flags_nxt[`UCR_FL_BREAK]   = 1'b0;
        flags_nxt[`UCR_FL_NOISE]   = 1'b0;
    end
    // New events win over the clear in the same cycle
    if (rx_char_valid)
    begin
        if (serial_port_flags_r[`UCR_FL_RXFULL] & ~rd_data)
        begin
            flags_nxt[`UCR_FL_OVERRUN] = 1'b1;
        end
        flags_nxt[`UCR_FL_RXFULL] = 1'b1;
        if (rx_parity_err & serial_port_setup_r[`UCR_SU_PAREN])
        begin
            flags_nxt[`UCR_FL_PARITY] = 1'b1;
        end
        if (rx_frame_err)
        begin
            flags_nxt[`UCR_FL_FRAMING] = 1'b1;
        end
    end
    if (rx_break_seen)
    begin
        flags_nxt[`UCR_FL_BREAK] = 1'b1;
    end
    if (rx_noise_seen)
    begin
        flags_nxt[`UCR_FL_NOISE] = 1'b1;
    end
    // Ready clears on a write, sets again once the shifter takes it
    if (wr_data)
    begin
        flags_nxt[`UCR_FL_TXRDY] = 1'b0;
    end
    else if (tx_taken | ~tx_hold_valid)
    begin
        flags_nxt[`UCR_FL_TXRDY] = 1'b1;
    end
    flags_nxt[`UCR_FL_TXDONE] = ~tx_busy;
end

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        serial_port_flags_r    <= `UCR_FLAGS_RST;
        receive_byte_holding_r <= 8'h00;
        noise_filter_on        <= 1'b0;
        tx_hold_valid          <= 1'b0;
        tx_hold_byte           <= 8'h00;
    end
    else if (ce)
    begin
        if (stop_recover)
        begin
            serial_port_flags_r <= `UCR_FLAGS_RST;
        end
        else
        begin
            serial_port_flags_r <= flags_nxt;
        end
        if (rx_char_valid)
        begin
            receive_byte_holding_r <= rx_char;
        end
        if (wr_flags)
        begin
            noise_filter_on <= wd[`UCR_FL_NOISE];
        end
        if (wr_data)
        begin
            tx_hold_valid <= 1'b1;
            tx_hold_byte  <= wd;
        end
        else if (tx_taken)
        begin
            tx_hold_valid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Setup register and bit rate generator

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        serial_port_setup_r      <= `UCR_SETUP_RST;
        bit_rate_divisor_value_r <= `UCR_DIVISOR_RST;
        bit_rate_divider_r       <= `UCR_DIVISOR_RST;
        bit_rate_tick            <= 1'b0;
        tx_enable                <= 1'b0;
        rx_enable                <= 1'b0;
        parity_enable            <= 1'b0;
        parity_odd               <= 1'b0;
        two_stop_bits            <= 1'b0;
        tx_force_low             <= 1'b0;
    end
    else if (ce)
    begin
        // Stop recovery leaves these untouched
        if (wr_setup)
        begin
            serial_port_setup_r <= wd;
        end
        if (wr_div)
        begin
            bit_rate_divisor_value_r <= wd;
        end
        if (brg_reload)
        begin
            bit_rate_divider_r <= bit_rate_divisor_value_r;
        end
        else if (brg_run)
        begin
            bit_rate_divider_r <= bit_rate_divider_r - 8'h01;
        end
        // Serial timing ticks stop while the generator is a timer
        bit_rate_tick <= brg_reload & ~timer_mode;
        tx_enable     <= serial_port_setup_r[`UCR_SU_TXEN];
        rx_enable     <= serial_port_setup_r[`UCR_SU_RXEN];
        parity_enable <= serial_port_setup_r[`UCR_SU_PAREN];
        parity_odd    <= serial_port_setup_r[`UCR_SU_PARODD];
        two_stop_bits <= serial_port_setup_r[`UCR_SU_STOP2];
        tx_force_low  <= serial_port_setup_r[`UCR_SU_BREAK];
    end
end

////////////////////////////////////////////////////////////////////////////
// Interrupts

always @*
begin
    irq_stat_nxt = irq_stat_r;
    if (wr_istat)
    begin
        irq_stat_nxt = irq_stat_r & ~wd[3:0];
    end
    // Set beats the write-one clear
    if (rx_char_valid)
    begin
        irq_stat_nxt[`UCR_IS_RX] = 1'b1;
    end
    if (tx_taken)
    begin
        irq_stat_nxt[`UCR_IS_TX] = 1'b1;
    end
    if ((rx_char_valid & (rx_frame_err | rx_parity_err)) | rx_break_seen)
    begin
        irq_stat_nxt[`UCR_IS_ERR] = 1'b1;
    end
    if (brg_reload & timer_mode)
    begin
        irq_stat_nxt[`UCR_IS_TIMER] = 1'b1;
    end
end

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        irq_stat_r <= `UCR_IRQ_RST;
        irq_mask_r <= `UCR_IRQ_RST;
        irq        <= 1'b0;
    end
    else if (ce)
    begin
        irq_stat_r <= irq_stat_nxt;
        if (wr_imask)
        begin
            irq_mask_r <= wd[3:0];
        end
        irq <= (|(irq_stat_r & irq_mask_r))
               & serial_port_setup_r[`UCR_SU_IRQEN]
               & global_irq_mask;
    end
end

endmodule

// file: verif/ucr_assertions.sv
`timescale 1ns/1ps
module ucr_checker (
    // Clock and bus
    input wire        hclk,
    input wire        hresetn,
    input wire        ce,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire        hready,
    input wire        hreadyout,
    input wire        hresp,
    input wire [31:0] hrdata,
    // Outputs watched, and the global mask input
    input wire        tx_hold_valid,
    input wire        tx_enable,
    input wire        rx_enable,
    input wire        tx_force_low,
    input wire        noise_filter_on,
    input wire        bit_rate_tick,
    input wire        global_irq_mask,
    input wire        irq
);
    wire       aw  = hsel && htrans[1] && hready && hwrite;
    wire       en  = tx_enable || rx_enable;
    wire [2:0] cfg = {tx_enable, rx_enable, tx_force_low};

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_resp_okay: assert property (!hresp)
        else $error("error response");
    a_ready_holds: assert property (hreadyout |=> hreadyout)
        else $error("wait state seen");
    a_upper_zero: assert property (hrdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_irq_gate: assert property ($past(ce) && !$past(global_irq_mask) |-> !irq)
        else $error("irq with global mask off");
    a_hold_cause: assert property ($rose(tx_hold_valid) |->
        $past(aw && haddr == 32'h3C4, 2))
        else $error("hold byte without write");
    a_cfg_cause: assert property ($changed(cfg) |->
        $past(aw && haddr == 32'h3CC, 2) || $past(aw && haddr == 32'h3CC, 3))
        else $error("setup output moved alone");
    a_filter_cause: assert property ($changed(noise_filter_on) |->
        $past(aw && haddr == 32'h3C8, 2) || $past(aw && haddr == 32'h3C8, 3))
        else $error("filter moved alone");
    a_tick_uart: assert property (bit_rate_tick |->
        en || $past(en) || $past(en, 2))
        else $error("tick with port disabled");
endmodule

// file: verif/ucr_shifter_model.sv
`timescale 1ns/1ps
module ucr_shifter_model (
    // Clock
    input  wire       hclk,
    // Transmit shifter
    input  wire       tx_hold_valid,
    output reg        tx_taken,
    output reg        tx_busy,
    // Receive shifter
    output wire       rx_char_valid,
    output reg  [7:0] rx_char,
    output wire       rx_parity_err,
    output wire       rx_frame_err,
    output wire       rx_break_seen,
    output wire       rx_noise_seen
);
    reg     [4:0] ev_r;
    integer       tx_delay;

    assign {rx_char_valid, rx_noise_seen, rx_break_seen, rx_frame_err,
            rx_parity_err} = ev_r;

    // One-cycle event: {valid, noise, break, framing, parity}
    task rx_pulse(input [7:0] b, input [4:0] ev);
        begin
            @(posedge hclk);
            ev_r <= ev;
            rx_char <= b;
            @(posedge hclk);
            ev_r <= 5'h00;
            rx_char <= ~b;
        end
    endtask

    initial
    begin
        tx_delay = 2;
        tx_taken = 1'b0;
        tx_busy = 1'b0;
        ev_r = 5'h00;
        rx_char = 8'h00;
        forever
        begin
            @(posedge hclk);
            if (tx_hold_valid === 1'b1)
            begin
                repeat (tx_delay) @(posedge hclk);
                tx_taken <= 1'b1;
                tx_busy <= 1'b1;
                @(posedge hclk);
                tx_taken <= 1'b0;
                repeat (9) @(posedge hclk);
                tx_busy <= 1'b0;
            end
        end
    end
endmodule

// file: verif/ucr_top_test.sv
`timescale 1ns/1ps
`include "ucr_regs.vh"
module ucr_top_test;
    reg         hclk, hresetn, ce, hsel, hwrite, stop_recover;
    reg         global_irq_mask;
    reg  [1:0]  htrans;
    reg  [2:0]  hsize;
    reg  [31:0] haddr, hwdata, d, d2;
    wire [31:0] hrdata;
    wire [7:0]  rx_char, tx_hold_byte;
    wire        hreadyout, hresp, tx_hold_valid, tx_force_low, irq;
    wire        rx_char_valid, rx_parity_err, rx_frame_err, rx_break_seen;
    wire        rx_noise_seen, tx_taken, tx_busy, tx_enable, rx_enable;
    wire        parity_enable, parity_odd, two_stop_bits;
    wire        noise_filter_on, bit_rate_tick;
    wire        hready = hreadyout;
    integer     fails, checks_done, i;

    ucr_top ucr_top_i (.*);
    ucr_shifter_model ucr_shifter_model_i (.*);

    task end_sim(input to);
        begin
            if (to)
                fails = fails + 1;
            $display("checks %0d mismatches %0d", checks_done, fails);
            if (fails == 0 && checks_done > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    task wait_rdy;
        integer n;
        begin
            n = 0;
            @(posedge hclk);
            while (hready !== 1'b1)
            begin
                n = n + 1;
                if (n > 99)
                    end_sim(1'b1);
                @(posedge hclk);
            end
        end
    endtask

    task ahb(input w, input [31:0] a, input [31:0] wd);
        begin
            hsel <= 1'b1;
            htrans <= 2'b10;
            haddr <= a;
            hwrite <= w;
            wait_rdy;
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= wd;
            wait_rdy;
            d = hrdata;
        end
    endtask

    task wr(input [7:0] i, input [7:0] v);
        ahb(1'b1, {22'h0, i, 2'b00}, {24'h0, v});
    endtask

    task rd(input [7:0] i);
        ahb(1'b0, {22'h0, i, 2'b00}, 32'h0);
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] s);
        begin
            checks_done = checks_done + 1;
            if (s !== e)
            begin
                fails = fails + 1;
                $display("unexpected %s: expected %h seen %h", nm, e, s);
            end
        end
    endtask

    initial
    begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    initial
    begin
        {fails, checks_done} = 64'h0;
        {hresetn, hsel, hwrite, stop_recover, global_irq_mask} = 5'h00;
        {htrans, haddr, hwdata} = 66'h0;
        ce = 1'b1;
        hsize = 3'h2;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(`UCR_IDX_FLAGS);
        chk("flags", 32'h06, d);
        rd(`UCR_IDX_SETUP);
        chk("setup", 32'h00, d);
        ahb(1'b0, 32'h400, 32'h0);
        chk("unmapped", 32'h0, d);
        wr(`UCR_IDX_SETUP, 8'hDE);
        repeat (2) @(posedge hclk);
        chk("cfg", 32'h3F, {26'h0, tx_enable, rx_enable, parity_enable,
            parity_odd, two_stop_bits, tx_force_low});
        stop_recover <= 1'b1;
        @(posedge hclk);
        stop_recover <= 1'b0;
        rd(`UCR_IDX_SETUP);
        chk("setup", 32'hDE, d);
        $display("setup test done");
        wr(`UCR_IDX_SETUP, 8'hF0);
        wr(`UCR_IDX_IRQ_MASK, 8'h05);
        global_irq_mask <= 1'b1;
        ucr_shifter_model_i.rx_pulse(8'h5A, 5'h11);
        ucr_shifter_model_i.rx_pulse(8'hA5, 5'h12);
        ucr_shifter_model_i.rx_pulse(8'h00, 5'h0C);
        rd(`UCR_IDX_FLAGS);
        chk("flags", 32'hFB, d & 32'hFB);
        chk("irq", 32'h1, {31'h0, irq});
        global_irq_mask <= 1'b0;
        repeat (2) @(posedge hclk);
        chk("irq", 32'h0, {31'h0, irq});
        rd(`UCR_IDX_DATA);
        chk("data", 32'hA5, d);
        rd(`UCR_IDX_FLAGS);
        chk("flags", 32'h02, d & 32'hFB);
        wr(`UCR_IDX_IRQ_STAT, 8'h0F);
        rd(`UCR_IDX_IRQ_STAT);
        chk("irq_stat", 32'h0, d);
        $display("receive test done");
        ucr_shifter_model_i.tx_delay = 20;
        wr(`UCR_IDX_DATA, 8'h3C);
        rd(`UCR_IDX_FLAGS);
        chk("txready", 32'h0, d & 32'h04);
        chk("hold", 32'h3C, {24'h0, tx_hold_byte});
        repeat (24) @(posedge hclk);
        rd(`UCR_IDX_FLAGS);
        chk("txdone", 32'h0, d & 32'h02);
        repeat (10) @(posedge hclk);
        rd(`UCR_IDX_FLAGS);
        chk("txidle", 32'h06, d & 32'h06);
        $display("transmit test done");
        // Counter starts from all ones, so let it wrap before counting
        wr(`UCR_IDX_DIVISOR, 8'h03);
        repeat (300) @(posedge hclk);
        d2 = 32'h0;
        for (i = 0; i < 40; i = i + 1)
        begin
            @(posedge hclk);
            d2 = d2 + bit_rate_tick;
        end
        chk("ticks", 32'h0A, d2);
        wr(`UCR_IDX_SETUP, 8'h21);
        wr(`UCR_IDX_IRQ_MASK, 8'h08);
        global_irq_mask <= 1'b1;
        for (i = 0; i < 20; i = i + 1)
        begin
            @(posedge hclk);
            chk("tick", 32'h0, {31'h0, bit_rate_tick});
        end
        rd(`UCR_IDX_IRQ_STAT);
        chk("timer_stat", 32'h08, d & 32'h08);
        chk("irq", 32'h1, {31'h0, irq});
        rd(`UCR_IDX_DIVISOR);
        d2 = d;
        rd(`UCR_IDX_DIVISOR);
        chk("live", 32'h1, {31'h0, d != d2 && d < 4});
        wr(`UCR_IDX_FLAGS, 8'h01);
        repeat (2) @(posedge hclk);
        chk("filter", 32'h1, {31'h0, noise_filter_on});
        $display("timer test done");
        end_sim(1'b0);
    end
endmodule

bind ucr_top ucr_checker ucr_checker_i (.*);
